// >>> rtl/cctm_params.svh
// cctm_params.svh: timing budgets (clocks, reads, writes) of the cycle timing model
// assumes: included by the timing engine only, not by the package; definitions only
`ifndef CCTM_PARAMS_SVH
`define CCTM_PARAMS_SVH

`define CCTM_CLK_PERIOD_NS 10
`define CCTM_BUS_CYCLE_CLKS 4
// budgets packed as {clocks[7:0], reads[5:0], writes[5:0]}
`define CCTM_B(c, r, w) {8'(c), 6'(r), 6'(w)}
`define CCTM_XB_REG `CCTM_B(4, 1, 0)
`define CCTM_XB_MEM `CCTM_B(18, 3, 1)
`define CCTM_XB_LCONT `CCTM_B(22, 2, 1)
`define CCTM_XB_LCC `CCTM_B(28, 4, 1)
`define CCTM_XB_LEXP `CCTM_B(26, 4, 1)
`define CCTM_XL_REG `CCTM_B(6, 1, 0)
`define CCTM_XL_MEM `CCTM_B(30, 5, 2)
`define CCTM_XL_LCONT `CCTM_B(32, 4, 2)
`define CCTM_XL_LCC `CCTM_B(38, 6, 2)
`define CCTM_XL_LEXP `CCTM_B(36, 6, 2)
`define CCTM_CB_MEM `CCTM_B(12, 3, 0)
`define CCTM_CB_LCONT `CCTM_B(14, 2, 0)
`define CCTM_CB_LCC `CCTM_B(20, 4, 0)
`define CCTM_CB_LEXP `CCTM_B(18, 4, 0)
`define CCTM_CL_MEM `CCTM_B(20, 5, 0)
`define CCTM_CL_LCONT `CCTM_B(24, 4, 0)
`define CCTM_CL_LCC `CCTM_B(30, 6, 0)
`define CCTM_CL_LEXP `CCTM_B(26, 6, 0)
`define CCTM_D_REG `CCTM_B(6, 1, 0)
`define CCTM_D_MEM `CCTM_B(18, 3, 1)
`define CCTM_D_LCONT `CCTM_B(24, 2, 1)
`define CCTM_D_LCC `CCTM_B(30, 4, 1)
`define CCTM_D_LEXP `CCTM_B(28, 4, 1)
`define CCTM_BOUNDS `CCTM_B(8, 1, 0)
`define CCTM_STSTORE `CCTM_B(8, 1, 1)
`define CCTM_PM_TOMEM_W `CCTM_B(16, 2, 2)
`define CCTM_PM_TOMEM_L `CCTM_B(24, 2, 4)
`define CCTM_PM_FRMEM_W `CCTM_B(16, 4, 0)
`define CCTM_PM_FRMEM_L `CCTM_B(24, 6, 0)
`define CCTM_CRM_OUT `CCTM_B(10, 2, 0)
`define CCTM_CRM_IN `CCTM_B(12, 2, 0)
`define CCTM_EX_BUSERR `CCTM_B(126, 4, 26)
`define CCTM_EX_INTR `CCTM_B(46, 5, 4)
`define CCTM_EX_BKPT `CCTM_B(45, 5, 4)
`define CCTM_EX_BOUNDS `CCTM_B(44, 5, 4)
`define CCTM_EX_BADCR `CCTM_B(46, 5, 4)
`define CCTM_RESET_EXIT `CCTM_B(40, 6, 0)

`endif

// >>> rtl/cctm_pkg.sv
// cctm_pkg: operation codes, forms and states of the cycle timing model
// assumes: numeric budgets live in cctm_params.svh
package cctm_pkg;
    typedef enum logic [3:0] {
        CCTM_OP_XADD = 4'h0, CCTM_OP_XSUB = 4'h1, CCTM_OP_MCMP = 4'h2,
        CCTM_OP_DADD = 4'h3, CCTM_OP_DSUB = 4'h4, CCTM_OP_BOUNDS = 4'h5,
        CCTM_OP_STSTORE = 4'h6, CCTM_OP_PMOVE = 4'h7, CCTM_OP_CRMOVE = 4'h8,
        CCTM_OP_EX_BUSERR = 4'h9, CCTM_OP_EX_ADRERR = 4'ha, CCTM_OP_EX_INTR = 4'hb,
        CCTM_OP_EX_BKPT = 4'hc, CCTM_OP_EX_BOUNDS = 4'hd
    } cctm_op_t;
    // form selects register, memory or a loop-mode outcome
    typedef enum logic [2:0] {
        CCTM_F_REG = 3'h0, CCTM_F_MEM = 3'h1, CCTM_F_LCONT = 3'h2,
        CCTM_F_LCC = 3'h3, CCTM_F_LEXP = 3'h4
    } cctm_form_t;
    typedef enum logic [1:0] {CCTM_SZ_BYTE = 2'h0, CCTM_SZ_WORD = 2'h1, CCTM_SZ_LONG = 2'h2} cctm_size_t;
    typedef enum logic [2:0] {
        CCTM_S_IDLE = 3'b001, CCTM_S_RUN = 3'b010, CCTM_S_BOOT = 3'b100
    } cctm_state_t;
endpackage : cctm_pkg

// >>> rtl/cctm_engine.sv
// cctm_engine: plays out the clock, read and write budget of one operation
// assumes: one 100 MHz clock; memory answers each bus cycle in four clocks unless it
// holds wait_i; reset and halt inputs arrive asynchronously from pins.
// Functional notes
// - every operation is timed by total clocks, read bus cycles and write bus cycles.
// - multiprecision budgets include both operand fetches, the operation, the store and the prefetch.
// - memory compare uses postincrement on both operands; extended and decimal add/subtract use predecrement on both in their non-register forms.
// - extended add/subtract byte/word costs 4(1/0), 18(3/1), loops 22(2/1), 28(4/1), 26(4/1).
// - extended add/subtract long costs 6(1/0), 30(5/2), loops 32(4/2), 38(6/2), 36(6/2).
// - memory compare costs 12(3/0), 14(2/0), 20(4/0), 18(4/0); long 20, 24, 30, 26.
// - decimal add/subtract costs 6(1/0), 18(3/1), loops 24(2/1), 30(4/1), 28(4/1).
// - flagged entries add the effective-address clocks, reads and writes, e.g. bounds check 8(1/0), its exception 44.
// - status store to memory costs 8(1/1) plus a non-fetching address time with no operand read.
// - peripheral move costs 16(2/2)/24(2/4) to memory, 16(4/0)/24(6/0) from it; control move 10 out, 12 in.
// - bus and address error exceptions cost 126 clocks with 4 reads and 26 writes, all stacking included.
// - interrupt exception costs 46(5/4) and breakpoint 45, with a four-clock acknowledge cycle.
// - after reset and halt are seen negated, execution starts 40 clocks later after 6 reads and no writes.
// - a move to an unimplemented control register raises an exception of at most 46(5/4).
`timescale 1ns/1ps
`include "cctm_params.svh"

module cctm_engine
    import cctm_pkg::*;
#(
    parameter int CNT_W = 12
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // processor reset and halt pins, active low, asynchronous
    input wire logic cpu_reset_n_i,
    input wire logic cpu_halt_n_i,
    // operation request
    input wire logic start_i,
    input wire cctm_op_t op_i,
    input wire cctm_size_t size_i,
    input wire cctm_form_t form_i,
    input wire logic dir_to_mem_i,
    input wire logic cr_valid_i,
    input wire logic [7:0] ea_clks_i,
    input wire logic [5:0] ea_reads_i,
    input wire logic [5:0] ea_writes_i,
    // bus answer: extends the current bus cycle
    input wire logic wait_i,
    // status
    output logic ready_o,
    output logic exec_o,
    output logic done_o,
    output logic bus_read_o,
    output logic bus_write_o,
    output logic addr_postinc_o,
    output logic addr_predec_o,
    output logic [CNT_W-1:0] clks_o,
    output logic [5:0] reads_o,
    output logic [5:0] writes_o,
    output logic bad_cr_exc_o
);
    localparam logic [7:0] BUS_CLKS = 8'(`CCTM_BUS_CYCLE_CLKS);

    // elaboration check: the longest budget with address time needs nine bits
    if (CNT_W < 9) begin : g_cnt_w_check
        $error("cctm_engine: CNT_W must be at least 9");
    end

    // pin synchronisers: change counts once stages two and three agree
    logic [2:0] rst_sync_r, rst_sync_nxt;
    logic [2:0] halt_sync_r, halt_sync_nxt;
    logic pins_neg_r, pins_neg_nxt;

    always_comb begin
        rst_sync_nxt = {rst_sync_r[1:0], cpu_reset_n_i};
        halt_sync_nxt = {halt_sync_r[1:0], cpu_halt_n_i};
        pins_neg_nxt = pins_neg_r;
        if (rst_sync_r[2] == rst_sync_r[1] && halt_sync_r[2] == halt_sync_r[1]) begin
            pins_neg_nxt = rst_sync_r[1] & halt_sync_r[1];
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            rst_sync_r <= 3'h0;
            halt_sync_r <= 3'h0;
            pins_neg_r <= 1'b0;
        end else begin
            rst_sync_r <= rst_sync_nxt;
            halt_sync_r <= halt_sync_nxt;
            pins_neg_r <= pins_neg_nxt;
        end
    end

    // budget lookup, packed {clocks, reads, writes}
    logic [19:0] base_b;
    logic add_ea;
    logic bad_cr;
    always_comb begin
        base_b = `CCTM_B(4, 1, 0);
        add_ea = 1'b0;
        bad_cr = 1'b0;
        case (op_i)
            CCTM_OP_XADD, CCTM_OP_XSUB: begin
                case (form_i)
                    CCTM_F_REG: base_b = (size_i == CCTM_SZ_LONG) ? `CCTM_XL_REG : `CCTM_XB_REG;
                    CCTM_F_MEM: base_b = (size_i == CCTM_SZ_LONG) ? `CCTM_XL_MEM : `CCTM_XB_MEM;
                    CCTM_F_LCONT: base_b = (size_i == CCTM_SZ_LONG) ? `CCTM_XL_LCONT : `CCTM_XB_LCONT;
                    CCTM_F_LCC: base_b = (size_i == CCTM_SZ_LONG) ? `CCTM_XL_LCC : `CCTM_XB_LCC;
                    default: base_b = (size_i == CCTM_SZ_LONG) ? `CCTM_XL_LEXP : `CCTM_XB_LEXP;
                endcase
            end
            CCTM_OP_MCMP: begin
                case (form_i)
                    CCTM_F_LCONT: base_b = (size_i == CCTM_SZ_LONG) ? `CCTM_CL_LCONT : `CCTM_CB_LCONT;
                    CCTM_F_LCC: base_b = (size_i == CCTM_SZ_LONG) ? `CCTM_CL_LCC : `CCTM_CB_LCC;
                    CCTM_F_LEXP: base_b = (size_i == CCTM_SZ_LONG) ? `CCTM_CL_LEXP : `CCTM_CB_LEXP;
                    default: base_b = (size_i == CCTM_SZ_LONG) ? `CCTM_CL_MEM : `CCTM_CB_MEM;
                endcase
            end
            CCTM_OP_DADD, CCTM_OP_DSUB: begin
                case (form_i)
                    CCTM_F_REG: base_b = `CCTM_D_REG;
                    CCTM_F_MEM: base_b = `CCTM_D_MEM;
                    CCTM_F_LCONT: base_b = `CCTM_D_LCONT;
                    CCTM_F_LCC: base_b = `CCTM_D_LCC;
                    default: base_b = `CCTM_D_LEXP;
                endcase
            end
            CCTM_OP_BOUNDS: begin
                base_b = `CCTM_BOUNDS;
                add_ea = 1'b1;
            end
            CCTM_OP_STSTORE: begin
                base_b = `CCTM_STSTORE;
                add_ea = 1'b1;
            end
            CCTM_OP_PMOVE: begin
                if (dir_to_mem_i) begin
                    base_b = (size_i == CCTM_SZ_LONG) ? `CCTM_PM_TOMEM_L : `CCTM_PM_TOMEM_W;
                end else begin
                    base_b = (size_i == CCTM_SZ_LONG) ? `CCTM_PM_FRMEM_L : `CCTM_PM_FRMEM_W;
                end
            end
            CCTM_OP_CRMOVE: begin
                if (!cr_valid_i) begin
                    base_b = `CCTM_EX_BADCR;
                    bad_cr = 1'b1;
                end else begin
                    base_b = dir_to_mem_i ? `CCTM_CRM_OUT : `CCTM_CRM_IN;
                end
            end
            CCTM_OP_EX_BUSERR, CCTM_OP_EX_ADRERR: base_b = `CCTM_EX_BUSERR;
            CCTM_OP_EX_INTR: base_b = `CCTM_EX_INTR;
            CCTM_OP_EX_BKPT: base_b = `CCTM_EX_BKPT;
            CCTM_OP_EX_BOUNDS: begin
                base_b = `CCTM_EX_BOUNDS;
                add_ea = 1'b1;
            end
            default: base_b = `CCTM_B(4, 1, 0);
        endcase
    end

    // budget totals; a status store never reads its operand
    logic [8:0] tot_clks;
    logic [5:0] tot_reads;
    logic [5:0] tot_writes;
    always_comb begin
        tot_clks = {1'b0, base_b[19:12]};
        tot_reads = base_b[11:6];
        tot_writes = base_b[5:0];
        if (add_ea) begin
            tot_clks = tot_clks + {1'b0, ea_clks_i};
            // no operand read in address calc
            tot_reads = tot_reads + ((op_i == CCTM_OP_STSTORE) ? 6'h0 : ea_reads_i);
            tot_writes = tot_writes + ea_writes_i;
        end
    end

    // sequencer: reads first, then writes, then internal clocks
    cctm_state_t state_r, state_nxt;
    logic [CNT_W-1:0] clk_cnt_r, clk_cnt_nxt;
    logic [5:0] rd_left_r, rd_left_nxt;
    logic [5:0] wr_left_r, wr_left_nxt;
    logic [7:0] idle_left_r, idle_left_nxt;
    logic [1:0] phase_r, phase_nxt;
    logic [5:0] reads_r, reads_nxt;
    logic [5:0] writes_r, writes_nxt;
    logic exec_r, exec_nxt;
    logic done_r, done_nxt;
    logic postinc_r, postinc_nxt;
    logic predec_r, predec_nxt;
    logic bad_cr_r, bad_cr_nxt;
    logic in_bus;
    logic last_clk;

    assign in_bus = (rd_left_r != 6'h0) || (wr_left_r != 6'h0);
    // wait states stretch the fourth clock only
    assign last_clk = in_bus ? (phase_r == 2'(BUS_CLKS - 8'h1) && !wait_i && rd_left_r + wr_left_r == 6'h1
                                && idle_left_r == 8'h0)
                             : (idle_left_r == 8'h1);

    always_comb begin
        state_nxt = state_r;
        clk_cnt_nxt = clk_cnt_r;
        rd_left_nxt = rd_left_r;
        wr_left_nxt = wr_left_r;
        idle_left_nxt = idle_left_r;
        phase_nxt = phase_r;
        reads_nxt = reads_r;
        writes_nxt = writes_r;
        exec_nxt = exec_r;
        done_nxt = 1'b0;
        postinc_nxt = postinc_r;
        predec_nxt = predec_r;
        bad_cr_nxt = bad_cr_r;
        case (state_r)
            CCTM_S_IDLE: begin
                // reset exit timed from negated pins
                if (!pins_neg_r) begin
                    exec_nxt = 1'b0;
                end else if (!exec_r) begin
                    state_nxt = CCTM_S_BOOT;
                    clk_cnt_nxt = '0;
                    reads_nxt = 6'h0;
                    writes_nxt = 6'h0;
                    phase_nxt = 2'h0;
                    rd_left_nxt = 6'(`CCTM_RESET_EXIT >> 6);
                    wr_left_nxt = 6'h0;
                    idle_left_nxt = 8'(`CCTM_RESET_EXIT >> 12) - 8'(6'(`CCTM_RESET_EXIT >> 6)) * BUS_CLKS;
                end else if (start_i) begin
                    state_nxt = CCTM_S_RUN;
                    clk_cnt_nxt = '0;
                    reads_nxt = 6'h0;
                    writes_nxt = 6'h0;
                    phase_nxt = 2'h0;
                    rd_left_nxt = tot_reads;
                    wr_left_nxt = tot_writes;
                    idle_left_nxt = 8'(tot_clks - 9'(BUS_CLKS) * 9'(tot_reads + tot_writes));
                    postinc_nxt = (op_i == CCTM_OP_MCMP);
                    predec_nxt = (op_i inside {CCTM_OP_XADD, CCTM_OP_XSUB, CCTM_OP_DADD, CCTM_OP_DSUB})
                                 && form_i != CCTM_F_REG;
                    bad_cr_nxt = bad_cr;
                end
            end
            CCTM_S_RUN, CCTM_S_BOOT: begin
                if (!pins_neg_r) begin
                    state_nxt = CCTM_S_IDLE;
                    exec_nxt = 1'b0;
                end else begin
                    clk_cnt_nxt = clk_cnt_r + 1'b1;
                    if (in_bus) begin
                        if (phase_r != 2'(BUS_CLKS - 8'h1)) begin
                            phase_nxt = phase_r + 2'h1;
                        end else if (!wait_i) begin
                            phase_nxt = 2'h0;
                            if (rd_left_r != 6'h0) begin
                                rd_left_nxt = rd_left_r - 6'h1;
                                reads_nxt = reads_r + 6'h1;
                            end else begin
                                wr_left_nxt = wr_left_r - 6'h1;
                                writes_nxt = writes_r + 6'h1;
                            end
                        end
                    end else if (idle_left_r != 8'h0) begin
                        idle_left_nxt = idle_left_r - 8'h1;
                    end
                    if (last_clk) begin
                        state_nxt = CCTM_S_IDLE;
                        done_nxt = 1'b1;
                        exec_nxt = 1'b1;
                    end
                end
            end
            default: state_nxt = CCTM_S_IDLE;
        endcase
    end

    // state registers
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            state_r <= CCTM_S_IDLE;
            clk_cnt_r <= '0;
            rd_left_r <= 6'h0;
            wr_left_r <= 6'h0;
            idle_left_r <= 8'h0;
            phase_r <= 2'h0;
            reads_r <= 6'h0;
            writes_r <= 6'h0;
            exec_r <= 1'b0;
            done_r <= 1'b0;
            postinc_r <= 1'b0;
            predec_r <= 1'b0;
            bad_cr_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            clk_cnt_r <= clk_cnt_nxt;
            rd_left_r <= rd_left_nxt;
            wr_left_r <= wr_left_nxt;
            idle_left_r <= idle_left_nxt;
            phase_r <= phase_nxt;
            reads_r <= reads_nxt;
            writes_r <= writes_nxt;
            exec_r <= exec_nxt;
            done_r <= done_nxt;
            postinc_r <= postinc_nxt;
            predec_r <= predec_nxt;
            bad_cr_r <= bad_cr_nxt;
        end
    end

    // outputs; bus strobes are level through a whole bus cycle
    assign ready_o = (state_r == CCTM_S_IDLE) && exec_r;
    assign exec_o = exec_r;
    assign done_o = done_r;
    assign bus_read_o = (state_r != CCTM_S_IDLE) && (rd_left_r != 6'h0);
    assign bus_write_o = (state_r != CCTM_S_IDLE) && (rd_left_r == 6'h0) && (wr_left_r != 6'h0);
    assign addr_postinc_o = postinc_r;
    assign addr_predec_o = predec_r;
    assign clks_o = clk_cnt_r;
    assign reads_o = reads_r;
    assign writes_o = writes_r;
    assign bad_cr_exc_o = bad_cr_r;
endmodule : cctm_engine

// >>> sim/cctm_mem_model.sv
// cctm_mem_model: memory and peripherals answering the engine's bus cycles
// assumes: strobes are high through every clock of a bus cycle; slow_i asks for one wait per cycle
`timescale 1ns/1ps

module cctm_mem_model (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // bus strobes from the engine
    input wire logic bus_read_i,
    input wire logic bus_write_i,
    // answer speed and wait request
    input wire logic slow_i,
    output logic wait_o
);
    logic [1:0] phase;

    // prompt acknowledge cycle
    // the wait lands on the fourth clock, so a prompt partner never stretches a cycle
    always @(posedge mclk_i) begin
        if (!rst_n_i || !(bus_read_i || bus_write_i)) begin
            phase <= 2'h0;
            wait_o <= 1'b0;
        end else begin
            wait_o <= slow_i && (phase == 2'h2) && !wait_o;
            if (!wait_o) begin
                phase <= phase + 2'h1;
            end
        end
    end
endmodule : cctm_mem_model

// >>> sim/cctm_engine_chk.sv
// cctm_engine_chk: timing relations watched on the engine's ports
// assumes: bound to cctm_engine, one clock domain with synchronous reset
`timescale 1ns/1ps

module cctm_engine_chk
    import cctm_pkg::*;
#(
    parameter int CNT_W = 12
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // request side
    input wire logic start_i,
    input wire cctm_op_t op_i,
    input wire cctm_size_t size_i,
    input wire cctm_form_t form_i,
    input wire logic cr_valid_i,
    input wire logic wait_i,
    // status side
    input wire logic ready_o,
    input wire logic exec_o,
    input wire logic done_o,
    input wire logic bus_read_o,
    input wire logic bus_write_o,
    input wire logic addr_postinc_o,
    input wire logic addr_predec_o,
    input wire logic [CNT_W-1:0] clks_o,
    input wire logic [5:0] reads_o,
    input wire logic [5:0] writes_o,
    input wire logic bad_cr_exc_o
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);

    // a short extended-add register form without waits closes on its fourth clock
    chk_reg_budget: assert property ((ready_o && start_i && op_i == CCTM_OP_XADD && form_i == CCTM_F_REG
        && size_i != CCTM_SZ_LONG) ##1 (!wait_i) [*4] |=> done_o && clks_o == 4 && reads_o == 1 && writes_o == 0)
        else $error("register form budget wrong");
    chk_cmp_postinc: assert property (ready_o && start_i && op_i == CCTM_OP_MCMP |=> addr_postinc_o && !addr_predec_o)
        else $error("memory compare not postincrement");
    chk_arith_predec: assert property (ready_o && start_i && form_i != CCTM_F_REG && op_i inside {CCTM_OP_XADD,
        CCTM_OP_XSUB, CCTM_OP_DADD, CCTM_OP_DSUB} |=> addr_predec_o && !addr_postinc_o)
        else $error("memory arithmetic not predecrement");
    chk_strobe_excl: assert property (!(bus_read_o && bus_write_o))
        else $error("read and write strobes together");
    chk_cycle_len: assert property ($rose(bus_read_o) || $rose(bus_write_o) |-> (bus_read_o || bus_write_o) [*4])
        else $error("bus cycle shorter than four clocks");
    chk_reads_first: assert property ($rose(bus_write_o) |-> reads_o != 6'h00)
        else $error("write before any read");
    chk_done_pulse: assert property (done_o |-> ready_o ##1 !done_o)
        else $error("done not a single pulse");
    chk_reset_exit: assert property ($rose(exec_o) |-> done_o && reads_o == 6 && writes_o == 0)
        else $error("reset exit counts wrong");
    chk_badcr_trap: assert property (ready_o && start_i && op_i == CCTM_OP_CRMOVE && !cr_valid_i |=> bad_cr_exc_o)
        else $error("bad control register not flagged");
endmodule : cctm_engine_chk

// >>> sim/test_cctm_engine.sv
// test_cctm_engine: self-checking bench for the cycle timing engine
// assumes: partner model answers bus cycles; budgets are written out by hand below
`timescale 1ns/1ps

module test_cctm_engine;
    import cctm_pkg::*;
    logic mclk_i = 1'b0, rst_n_i = 1'b0, cpu_reset_n_i = 1'b0, cpu_halt_n_i = 1'b0;
    logic start_i = 1'b0, dir_to_mem_i = 1'b0, cr_valid_i = 1'b1, wait_i, slow = 1'b0;
    cctm_op_t op_i = CCTM_OP_XADD;
    cctm_size_t size_i = CCTM_SZ_BYTE;
    cctm_form_t form_i = CCTM_F_REG;
    logic [7:0] ea_clks_i = 8'h00;
    logic [5:0] ea_reads_i = 6'h00, ea_writes_i = 6'h00, reads_o, writes_o;
    logic ready_o, exec_o, done_o, bus_read_o, bus_write_o, addr_postinc_o, addr_predec_o, bad_cr_exc_o;
    logic [11:0] clks_o;
    int err_total = 0, total_checks = 0, cycles = 0, cnt;

    // 100 MHz clock
    always #5 mclk_i = ~mclk_i;

    cctm_engine #(.CNT_W(12)) cctm_engine_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .cpu_reset_n_i(cpu_reset_n_i),
        .cpu_halt_n_i(cpu_halt_n_i), .start_i(start_i), .op_i(op_i), .size_i(size_i), .form_i(form_i),
        .dir_to_mem_i(dir_to_mem_i), .cr_valid_i(cr_valid_i), .ea_clks_i(ea_clks_i), .ea_reads_i(ea_reads_i),
        .ea_writes_i(ea_writes_i), .wait_i(wait_i), .ready_o(ready_o), .exec_o(exec_o), .done_o(done_o),
        .bus_read_o(bus_read_o), .bus_write_o(bus_write_o), .addr_postinc_o(addr_postinc_o),
        .addr_predec_o(addr_predec_o), .clks_o(clks_o), .reads_o(reads_o), .writes_o(writes_o),
        .bad_cr_exc_o(bad_cr_exc_o));

    cctm_mem_model cctm_mem_model_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .bus_read_i(bus_read_o),
        .bus_write_i(bus_write_o), .slow_i(slow), .wait_o(wait_i));

    task automatic check(input logic [19:0] seen, input logic [19:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic results();
        $display("checks=%0d mismatches=%0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : results

    // a hang is cut short well above the expected run length
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            results();
        end
    end

    // one request back to back with the previous done; returns just after the done edge
    task automatic run(input cctm_op_t op, input cctm_size_t sz, input cctm_form_t fm, input int c, r, w);
        op_i = op;
        size_i = sz;
        form_i = fm;
        start_i = 1'b1;
        @(posedge mclk_i);
        #1 start_i = 1'b0;
        cnt = 0;
        do begin
            @(posedge mclk_i);
            #1 cnt++;
        end while (done_o !== 1'b1 && cnt < 300);
        check({cnt[7:0], reads_o, writes_o}, {c[7:0], r[5:0], w[5:0]});
        if (!slow) check(clks_o, c[11:0]);
    endtask : run

    task automatic test_reset_exit();
        rst_n_i = 1'b0;
        cpu_reset_n_i = 1'b0;
        cpu_halt_n_i = 1'b0;
        repeat (3) @(posedge mclk_i);
        #1 rst_n_i = 1'b1;
        repeat (2) @(posedge mclk_i);
        #1 cpu_reset_n_i = 1'b1;
        cpu_halt_n_i = 1'b1;
        cnt = 0;
        do begin
            @(posedge mclk_i);
            #1 cnt++;
        end while (done_o !== 1'b1 && cnt < 100);
        // three sync stages, the agreement flop and the boot take add five clocks to the 40
        check({cnt[7:0], clks_o}, {8'h2d, 12'h028});
        check({exec_o, ready_o, reads_o, writes_o}, {2'b11, 6'h06, 6'h00});
        $display("test reset exit ended");
    endtask : test_reset_exit

    task automatic test_extended();
        for (int i = 0; i < 2; i++) begin
            run(i ? CCTM_OP_XSUB : CCTM_OP_XADD, CCTM_SZ_WORD, CCTM_F_REG, 4, 1, 0);
            run(i ? CCTM_OP_XSUB : CCTM_OP_XADD, CCTM_SZ_BYTE, CCTM_F_MEM, 18, 3, 1);
            run(i ? CCTM_OP_XSUB : CCTM_OP_XADD, CCTM_SZ_BYTE, CCTM_F_LCONT, 22, 2, 1);
            run(i ? CCTM_OP_XSUB : CCTM_OP_XADD, CCTM_SZ_WORD, CCTM_F_LCC, 28, 4, 1);
            run(i ? CCTM_OP_XSUB : CCTM_OP_XADD, CCTM_SZ_BYTE, CCTM_F_LEXP, 26, 4, 1);
            run(i ? CCTM_OP_XSUB : CCTM_OP_XADD, CCTM_SZ_LONG, CCTM_F_REG, 6, 1, 0);
            run(i ? CCTM_OP_XSUB : CCTM_OP_XADD, CCTM_SZ_LONG, CCTM_F_MEM, 30, 5, 2);
            run(i ? CCTM_OP_XSUB : CCTM_OP_XADD, CCTM_SZ_LONG, CCTM_F_LCONT, 32, 4, 2);
            run(i ? CCTM_OP_XSUB : CCTM_OP_XADD, CCTM_SZ_LONG, CCTM_F_LCC, 38, 6, 2);
            run(i ? CCTM_OP_XSUB : CCTM_OP_XADD, CCTM_SZ_LONG, CCTM_F_LEXP, 36, 6, 2);
            check({addr_predec_o, addr_postinc_o}, 2'b10);
        end
        $display("test extended ended");
    endtask : test_extended

    task automatic test_compare_decimal();
        run(CCTM_OP_MCMP, CCTM_SZ_BYTE, CCTM_F_MEM, 12, 3, 0);
        run(CCTM_OP_MCMP, CCTM_SZ_WORD, CCTM_F_LCONT, 14, 2, 0);
        run(CCTM_OP_MCMP, CCTM_SZ_BYTE, CCTM_F_LCC, 20, 4, 0);
        run(CCTM_OP_MCMP, CCTM_SZ_WORD, CCTM_F_LEXP, 18, 4, 0);
        run(CCTM_OP_MCMP, CCTM_SZ_LONG, CCTM_F_MEM, 20, 5, 0);
        run(CCTM_OP_MCMP, CCTM_SZ_LONG, CCTM_F_LCONT, 24, 4, 0);
        run(CCTM_OP_MCMP, CCTM_SZ_LONG, CCTM_F_LCC, 30, 6, 0);
        run(CCTM_OP_MCMP, CCTM_SZ_LONG, CCTM_F_LEXP, 26, 6, 0);
        check({addr_predec_o, addr_postinc_o}, 2'b01);
        for (int i = 0; i < 2; i++) begin
            run(i ? CCTM_OP_DSUB : CCTM_OP_DADD, CCTM_SZ_BYTE, CCTM_F_REG, 6, 1, 0);
            run(i ? CCTM_OP_DSUB : CCTM_OP_DADD, CCTM_SZ_BYTE, CCTM_F_MEM, 18, 3, 1);
            run(i ? CCTM_OP_DSUB : CCTM_OP_DADD, CCTM_SZ_BYTE, CCTM_F_LCONT, 24, 2, 1);
            run(i ? CCTM_OP_DSUB : CCTM_OP_DADD, CCTM_SZ_BYTE, CCTM_F_LCC, 30, 4, 1);
            run(i ? CCTM_OP_DSUB : CCTM_OP_DADD, CCTM_SZ_BYTE, CCTM_F_LEXP, 28, 4, 1);
        end
        $display("test compare decimal ended");
    endtask : test_compare_decimal

    task automatic test_misc();
        ea_clks_i = 8'h06;
        ea_reads_i = 6'h01;
        ea_writes_i = 6'h01;
        run(CCTM_OP_BOUNDS, CCTM_SZ_WORD, CCTM_F_MEM, 14, 2, 1);
        run(CCTM_OP_EX_BOUNDS, CCTM_SZ_WORD, CCTM_F_MEM, 50, 6, 5);
        // the store must not add the address-calculation read
        run(CCTM_OP_STSTORE, CCTM_SZ_WORD, CCTM_F_MEM, 14, 1, 2);
        for (int d = 0; d < 2; d++) begin
            dir_to_mem_i = d[0];
            run(CCTM_OP_PMOVE, CCTM_SZ_WORD, CCTM_F_MEM, 16, d ? 2 : 4, d ? 2 : 0);
            run(CCTM_OP_PMOVE, CCTM_SZ_LONG, CCTM_F_MEM, 24, d ? 2 : 6, d ? 4 : 0);
            run(CCTM_OP_CRMOVE, CCTM_SZ_LONG, CCTM_F_MEM, d ? 10 : 12, 2, 0);
            check(bad_cr_exc_o, 1'b0);
        end
        cr_valid_i = 1'b0;
        run(CCTM_OP_CRMOVE, CCTM_SZ_LONG, CCTM_F_MEM, 46, 5, 4);
        check(bad_cr_exc_o, 1'b1);
        cr_valid_i = 1'b1;
        $display("test misc ended");
    endtask : test_misc

    task automatic test_exceptions();
        run(CCTM_OP_EX_BUSERR, CCTM_SZ_WORD, CCTM_F_MEM, 126, 4, 26);
        run(CCTM_OP_EX_ADRERR, CCTM_SZ_WORD, CCTM_F_MEM, 126, 4, 26);
        run(CCTM_OP_EX_INTR, CCTM_SZ_WORD, CCTM_F_MEM, 46, 5, 4);
        run(CCTM_OP_EX_BKPT, CCTM_SZ_WORD, CCTM_F_MEM, 45, 5, 4);
        $display("test exceptions ended");
    endtask : test_exceptions

    // waits stretch the clocks but leave the bus cycle counts alone
    task automatic test_wait_abort();
        slow = 1'b1;
        run(CCTM_OP_XADD, CCTM_SZ_BYTE, CCTM_F_MEM, 22, 3, 1);
        slow = 1'b0;
        op_i = CCTM_OP_EX_BUSERR;
        start_i = 1'b1;
        @(posedge mclk_i);
        #1 start_i = 1'b0;
        repeat (10) @(posedge mclk_i);
        #1 cpu_reset_n_i = 1'b0;
        repeat (8) @(posedge mclk_i);
        #1 check({exec_o, ready_o}, 2'b00);
        $display("test wait abort ended");
    endtask : test_wait_abort

    initial begin
        test_reset_exit();
        test_extended();
        test_compare_decimal();
        test_misc();
        test_exceptions();
        test_wait_abort();
        test_reset_exit();
        run(CCTM_OP_XADD, CCTM_SZ_BYTE, CCTM_F_REG, 4, 1, 0);
        results();
    end
endmodule : test_cctm_engine

bind cctm_engine cctm_engine_chk #(.CNT_W(CNT_W)) cctm_engine_chk_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .start_i(start_i), .op_i(op_i), .size_i(size_i), .form_i(form_i), .cr_valid_i(cr_valid_i), .wait_i(wait_i),
    .ready_o(ready_o), .exec_o(exec_o), .done_o(done_o), .bus_read_o(bus_read_o), .bus_write_o(bus_write_o),
    .addr_postinc_o(addr_postinc_o), .addr_predec_o(addr_predec_o), .clks_o(clks_o), .reads_o(reads_o),
    .writes_o(writes_o), .bad_cr_exc_o(bad_cr_exc_o));
